// >>> design/hsa_pkg.sv
// Package for the health status aggregator: word layouts, bit positions, reset values and carriers.
// Assumes a single 200 MHz clock domain and synchronous fault and alert inputs.
package hsa_pkg;

  localparam int WORD_W = 16;

  // Health summary word bit positions
  localparam int HS_FATAL_BIT = 0;
  localparam int HS_HW_FAULT_BIT = 1;
  localparam int HS_SW_FAULT_BIT = 3;
  localparam int HS_ALERT_BIT = 8;
  localparam int HS_HW_ALERT_BIT = 9;
  localparam int HS_SW_ALERT_BIT = 11;
  localparam int HS_SENSOR_ALERT_BIT = 12;

  // Hardware fault word bit positions
  localparam int HF_ACCEL_BIT = 4;
  localparam int HF_RATE_BIT = 5;
  localparam int HF_SELFCHECK_A_BIT = 6;
  localparam int HF_SELFCHECK_B_BIT = 7;

  // Software data fault word bit positions
  localparam int SD_CAL_CHECKSUM_BIT = 0;

  // Hardware alert word bit positions
  localparam int HA_NVM_OPEN_BIT = 3;
  localparam int HA_ACCEL_SEEN_BIT = 4;
  localparam int HA_RATE_SEEN_BIT = 5;

  // Sensor alert word bit positions
  localparam int SA_RANGE_BIT = 0;

  // Implemented bits of each word; everything else reads as zero
  localparam logic [15:0] HS_VALID_MASK = 16'h1b0b;
  localparam logic [15:0] HF_VALID_MASK = 16'h00f0;
  localparam logic [15:0] SD_VALID_MASK = 16'h0001;
  localparam logic [15:0] HA_VALID_MASK = 16'h0038;
  localparam logic [15:0] SA_VALID_MASK = 16'h0001;

  // Enable masks after reset: only range_exceeded is on
  localparam logic [15:0] HW_ALERT_MASK_RST = 16'h0000;
  localparam logic [15:0] SENSOR_ALERT_MASK_RST = 16'h0001;
  localparam logic [15:0] WORD_RST = 16'h0000;

  // Soft fault persistence counter defaults
  localparam int SOFT_CNT_W = 8;
  localparam logic [7:0] SOFT_INC = 8'h10;
  localparam logic [7:0] SOFT_THRESH = 8'h40;
  localparam int DECAY_US = 1;
  localparam int CLK_MHZ = 200;
  localparam int DECAY_CYCLES = DECAY_US * CLK_MHZ;

  // Raw low-level indications entering the block
  typedef struct packed {
    logic accel_fault;
    logic rate_sensor_fault;
    logic selfcheck_fault_a;
    logic selfcheck_fault_b;
    logic cal_checksum_fault;
  } hsa_hard_in_t;

  typedef struct packed {
    logic nvm_write_open;
    logic accel_anomaly_seen;
    logic rate_anomaly_seen;
    logic range_exceeded;
  } hsa_alert_in_t;

  // Registered words seen by the host
  typedef struct packed {
    logic [15:0] health_summary_word;
    logic [15:0] hw_fault_word;
    logic [15:0] sw_data_fault_word;
    logic [15:0] hw_alert_word;
    logic [15:0] sensor_alert_word;
  } hsa_words_t;

endpackage : hsa_pkg

// >>> design/hsa_tick.sv
// Divider that yields a one-cycle enable pulse every PERIOD clocks.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module hsa_tick #(
  parameter int PERIOD = hsa_pkg::DECAY_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  output logic tick
);

  localparam int CW = (PERIOD > 1) ? $clog2(PERIOD) : 1;

  if (PERIOD < 1) begin : g_bad_period
    $error("hsa_tick: PERIOD must be at least 1");
  end

  logic [CW-1:0] cnt_q;
  logic tick_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (cnt_q == CW'(PERIOD - 1)) begin
      cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + CW'(1);
      tick_q <= 1'b0;
    end
  end

  assign tick = tick_q;

endmodule : hsa_tick

// >>> design/hsa_persist.sv
// Leaky low-pass persistence counter for one soft fault category.
// Each soft event adds INC, each decay tick without an event removes one down to zero; reaching THRESH latches fatal.
// Assumes one clock, synchronous active-low reset, and a decay tick from a divider.
`timescale 1ns/10ps
module hsa_persist #(
  parameter int CNT_W = hsa_pkg::SOFT_CNT_W,
  parameter logic [CNT_W-1:0] INC = CNT_W'(hsa_pkg::SOFT_INC),
  parameter logic [CNT_W-1:0] THRESH = CNT_W'(hsa_pkg::SOFT_THRESH)
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic soft_event,
  input wire logic decay_tick,
  output logic persistent
);

  if (INC == '0 || THRESH == '0) begin : g_bad_step
    $error("hsa_persist: INC and THRESH must be nonzero");
  end

  logic [CNT_W-1:0] level_q;
  logic [CNT_W:0] sum;
  logic persistent_q;

  assign sum = {1'b0, level_q} + {1'b0, INC};

  // Isolated events leak away; only recurrence within the window climbs to threshold
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      level_q <= '0;
    end else if (soft_event) begin
      level_q <= sum[CNT_W] ? '1 : sum[CNT_W-1:0];
    end else if (decay_tick && level_q != '0) begin
      level_q <= level_q - CNT_W'(1);
    end
  end

  // Fatal is sticky until reset: a proven persistent fault must not flicker away
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      persistent_q <= 1'b0;
    end else if (level_q >= THRESH) begin
      persistent_q <= 1'b1;
    end
  end

  assign persistent = persistent_q;

endmodule : hsa_persist

// >>> design/hsa_aggregator.sv
// Health status aggregator: builds the fault and alert words and the health summary word.
// Assumes synchronous level inputs from the self-check logic and a host that reads the words.
`timescale 1ns/10ps
module hsa_aggregator #(
  parameter int DECAY_PERIOD = hsa_pkg::DECAY_CYCLES,
  parameter int SOFT_CNT_W = hsa_pkg::SOFT_CNT_W
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire hsa_pkg::hsa_hard_in_t hard_in,
  input wire hsa_pkg::hsa_alert_in_t alert_in,
  input wire logic hw_soft_event,
  input wire logic sw_soft_event,
  input wire logic link_soft_event,
  input wire logic link_alert_in,
  input wire logic sw_alert_in,
  input wire logic [15:0] hw_alert_mask_in,
  input wire logic hw_alert_mask_we,
  input wire logic [15:0] sensor_alert_mask_in,
  input wire logic sensor_alert_mask_we,
  input wire logic link_alert_en,
  input wire logic sw_alert_en,
  output hsa_pkg::hsa_words_t words,
  output logic [15:0] hw_alert_mask,
  output logic [15:0] sensor_alert_mask,
  output logic hw_fault_summary_soft,
  output logic sw_fault_summary_soft,
  output logic link_fault_summary_soft,
  output logic fatal_fault_pin
);

  // Refuse settings that the counters cannot serve
  if (DECAY_PERIOD < 1) begin : g_bad_period
    $error("hsa_aggregator: DECAY_PERIOD must be at least 1");
  end
  // The trip level and step must survive the cast into the counter width
  if (SOFT_CNT_W < 2 || (int'(hsa_pkg::SOFT_THRESH) >> SOFT_CNT_W) != 0
      || (int'(hsa_pkg::SOFT_INC) >> SOFT_CNT_W) != 0) begin : g_bad_width
    $error("hsa_aggregator: SOFT_CNT_W too narrow for the trip level");
  end

  // Each valid mask must hold exactly the bit positions that the logic drives,
  // so a slip in one of the two package lists cannot hide a bit or leak a reserved one
  localparam logic [15:0] HS_USED = (16'h0001 << hsa_pkg::HS_FATAL_BIT)
    | (16'h0001 << hsa_pkg::HS_HW_FAULT_BIT)
    | (16'h0001 << hsa_pkg::HS_SW_FAULT_BIT)
    | (16'h0001 << hsa_pkg::HS_ALERT_BIT)
    | (16'h0001 << hsa_pkg::HS_HW_ALERT_BIT)
    | (16'h0001 << hsa_pkg::HS_SW_ALERT_BIT)
    | (16'h0001 << hsa_pkg::HS_SENSOR_ALERT_BIT);
  localparam logic [15:0] HF_USED = (16'h0001 << hsa_pkg::HF_ACCEL_BIT)
    | (16'h0001 << hsa_pkg::HF_RATE_BIT)
    | (16'h0001 << hsa_pkg::HF_SELFCHECK_A_BIT)
    | (16'h0001 << hsa_pkg::HF_SELFCHECK_B_BIT);
  localparam logic [15:0] SD_USED = 16'h0001 << hsa_pkg::SD_CAL_CHECKSUM_BIT;
  localparam logic [15:0] HA_USED = (16'h0001 << hsa_pkg::HA_NVM_OPEN_BIT)
    | (16'h0001 << hsa_pkg::HA_ACCEL_SEEN_BIT)
    | (16'h0001 << hsa_pkg::HA_RATE_SEEN_BIT);
  localparam logic [15:0] SA_USED = 16'h0001 << hsa_pkg::SA_RANGE_BIT;

  if (HS_USED != hsa_pkg::HS_VALID_MASK) begin : g_bad_health_layout
    $error("hsa_aggregator: health word positions disagree with the valid mask");
  end
  if (HF_USED != hsa_pkg::HF_VALID_MASK || SD_USED != hsa_pkg::SD_VALID_MASK) begin : g_bad_fault_layout
    $error("hsa_aggregator: fault word positions disagree with the valid masks");
  end
  if (HA_USED != hsa_pkg::HA_VALID_MASK) begin : g_bad_hw_alert_layout
    $error("hsa_aggregator: hardware alert positions disagree with the valid mask");
  end
  if (SA_USED != hsa_pkg::SA_VALID_MASK) begin : g_bad_sensor_alert_layout
    $error("hsa_aggregator: sensor alert positions disagree with the valid mask");
  end

  // OR reduction over implemented bits only, so reserved bits can never count
  function automatic logic or_valid(input logic [15:0] w, input logic [15:0] valid);
    or_valid = |(w & valid);
  endfunction : or_valid

  logic decay_tick;
  logic hw_persist;
  logic sw_persist;
  logic link_persist;

  logic [15:0] hw_fault_d;
  logic [15:0] sw_data_d;
  logic [15:0] hw_alert_d;
  logic [15:0] sensor_alert_d;
  logic [15:0] health_d;

  logic [15:0] hw_fault_q;
  logic [15:0] sw_data_q;
  logic [15:0] hw_alert_q;
  logic [15:0] sensor_alert_q;
  logic [15:0] health_q;
  logic [15:0] hw_alert_mask_q;
  logic [15:0] sensor_alert_mask_q;
  logic hw_soft_q;
  logic sw_soft_q;
  logic link_soft_q;

  logic hw_fault_sum;
  logic data_fault_summary;
  logic sw_fault_sum;
  logic link_fault_sum;
  logic fatal_d;
  logic hw_alert_sum;
  logic sensor_alert_sum;
  logic sw_alert_sum;
  logic link_alert_sum;
  logic alert_sum;

  // The decay period sets the persistence window: a shorter period forgives faster
  hsa_tick #(
    .PERIOD(DECAY_PERIOD)
  ) u_tick (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tick(decay_tick)
  );

  // One leaky counter per soft category, all sharing one decay tick
  hsa_persist #(
    .CNT_W(SOFT_CNT_W),
    .INC(SOFT_CNT_W'(hsa_pkg::SOFT_INC)),
    .THRESH(SOFT_CNT_W'(hsa_pkg::SOFT_THRESH))
  ) u_hw_persist (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .soft_event(hw_soft_event),
    .decay_tick(decay_tick),
    .persistent(hw_persist)
  );

  hsa_persist #(
    .CNT_W(SOFT_CNT_W),
    .INC(SOFT_CNT_W'(hsa_pkg::SOFT_INC)),
    .THRESH(SOFT_CNT_W'(hsa_pkg::SOFT_THRESH))
  ) u_sw_persist (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .soft_event(sw_soft_event),
    .decay_tick(decay_tick),
    .persistent(sw_persist)
  );

  hsa_persist #(
    .CNT_W(SOFT_CNT_W),
    .INC(SOFT_CNT_W'(hsa_pkg::SOFT_INC)),
    .THRESH(SOFT_CNT_W'(hsa_pkg::SOFT_THRESH))
  ) u_link_persist (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .soft_event(link_soft_event),
    .decay_tick(decay_tick),
    .persistent(link_persist)
  );

  // Low-level fault word assembly
  always_comb begin
    hw_fault_d = hsa_pkg::WORD_RST;
    hw_fault_d[hsa_pkg::HF_ACCEL_BIT] = hard_in.accel_fault;
    hw_fault_d[hsa_pkg::HF_RATE_BIT] = hard_in.rate_sensor_fault;
    hw_fault_d[hsa_pkg::HF_SELFCHECK_A_BIT] = hard_in.selfcheck_fault_a;
    hw_fault_d[hsa_pkg::HF_SELFCHECK_B_BIT] = hard_in.selfcheck_fault_b;
    hw_fault_d = hw_fault_d & hsa_pkg::HF_VALID_MASK;
  end

  always_comb begin
    sw_data_d = hsa_pkg::WORD_RST;
    sw_data_d[hsa_pkg::SD_CAL_CHECKSUM_BIT] = hard_in.cal_checksum_fault;
    sw_data_d = sw_data_d & hsa_pkg::SD_VALID_MASK;
  end

  // Raw alert words, shown unmasked so the host sees every condition
  always_comb begin
    hw_alert_d = hsa_pkg::WORD_RST;
    hw_alert_d[hsa_pkg::HA_NVM_OPEN_BIT] = alert_in.nvm_write_open;
    hw_alert_d[hsa_pkg::HA_ACCEL_SEEN_BIT] = alert_in.accel_anomaly_seen;
    hw_alert_d[hsa_pkg::HA_RATE_SEEN_BIT] = alert_in.rate_anomaly_seen;
    hw_alert_d = hw_alert_d & hsa_pkg::HA_VALID_MASK;
  end

  always_comb begin
    sensor_alert_d = hsa_pkg::WORD_RST;
    sensor_alert_d[hsa_pkg::SA_RANGE_BIT] = alert_in.range_exceeded;
    sensor_alert_d = sensor_alert_d & hsa_pkg::SA_VALID_MASK;
  end

  // Intermediate fault signals: hard conditions plus momentary soft events.
  // The persistence counters alone decide whether soft events reach fatal.
  always_comb begin
    hw_fault_sum = or_valid(hw_fault_d, hsa_pkg::HF_VALID_MASK) | hw_soft_event;
    data_fault_summary = or_valid(sw_data_d, hsa_pkg::SD_VALID_MASK);
    sw_fault_sum = data_fault_summary | sw_soft_event;
    link_fault_sum = link_soft_event;
  end

  // Fatal: hard faults at once, soft faults only once persistent
  always_comb begin
    fatal_d = or_valid(hw_fault_d, hsa_pkg::HF_VALID_MASK)
      | data_fault_summary
      | hw_persist | sw_persist | link_persist;
  end

  // Alert summaries, each indication gated by its enable
  always_comb begin
    hw_alert_sum = or_valid(hw_alert_d & hw_alert_mask_q, hsa_pkg::HA_VALID_MASK);
    sensor_alert_sum = or_valid(sensor_alert_d & sensor_alert_mask_q, hsa_pkg::SA_VALID_MASK);
    sw_alert_sum = sw_alert_in & sw_alert_en;
    link_alert_sum = link_alert_in & link_alert_en;
    alert_sum = hw_alert_sum | sensor_alert_sum | sw_alert_sum | link_alert_sum;
  end

  // Bit 2 stays zero: the link category has no summary bit of its own
  always_comb begin
    health_d = hsa_pkg::WORD_RST;
    health_d[hsa_pkg::HS_FATAL_BIT] = fatal_d;
    health_d[hsa_pkg::HS_HW_FAULT_BIT] = hw_fault_sum;
    health_d[hsa_pkg::HS_SW_FAULT_BIT] = sw_fault_sum;
    health_d[hsa_pkg::HS_ALERT_BIT] = alert_sum;
    health_d[hsa_pkg::HS_HW_ALERT_BIT] = hw_alert_sum;
    health_d[hsa_pkg::HS_SW_ALERT_BIT] = sw_alert_sum;
    health_d[hsa_pkg::HS_SENSOR_ALERT_BIT] = sensor_alert_sum;
    health_d = health_d & hsa_pkg::HS_VALID_MASK;
  end

  // User enable masks; the range alert starts enabled
  // Reserved mask bits are dropped on load, so they can never gate a summary
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hw_alert_mask_q <= hsa_pkg::HW_ALERT_MASK_RST;
    end else if (hw_alert_mask_we) begin
      hw_alert_mask_q <= hw_alert_mask_in & hsa_pkg::HA_VALID_MASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sensor_alert_mask_q <= hsa_pkg::SENSOR_ALERT_MASK_RST;
    end else if (sensor_alert_mask_we) begin
      sensor_alert_mask_q <= sensor_alert_mask_in & hsa_pkg::SA_VALID_MASK;
    end
  end

  // Status words all load on the same edge, so a read never sees a torn set
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hw_fault_q <= hsa_pkg::WORD_RST;
    end else begin
      hw_fault_q <= hw_fault_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sw_data_q <= hsa_pkg::WORD_RST;
    end else begin
      sw_data_q <= sw_data_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hw_alert_q <= hsa_pkg::WORD_RST;
    end else begin
      hw_alert_q <= hw_alert_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sensor_alert_q <= hsa_pkg::WORD_RST;
    end else begin
      sensor_alert_q <= sensor_alert_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      health_q <= hsa_pkg::WORD_RST;
    end else begin
      health_q <= health_d;
    end
  end

  // One-cycle copies of each category's momentary soft event, so a host can
  // see a soft fault that has not (yet) proven persistent
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hw_soft_q <= 1'b0;
    end else begin
      hw_soft_q <= hw_soft_event;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sw_soft_q <= 1'b0;
    end else begin
      sw_soft_q <= sw_soft_event;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      link_soft_q <= 1'b0;
    end else begin
      link_soft_q <= link_fault_sum;
    end
  end

  assign words.health_summary_word = health_q;
  assign words.hw_fault_word = hw_fault_q;
  assign words.sw_data_fault_word = sw_data_q;
  assign words.hw_alert_word = hw_alert_q;
  assign words.sensor_alert_word = sensor_alert_q;
  assign hw_alert_mask = hw_alert_mask_q;
  assign sensor_alert_mask = sensor_alert_mask_q;
  assign hw_fault_summary_soft = hw_soft_q;
  assign sw_fault_summary_soft = sw_soft_q;
  assign link_fault_summary_soft = link_soft_q;

  // Pin taken from the same flop as bit 0, so the two can never disagree
  assign fatal_fault_pin = health_q[hsa_pkg::HS_FATAL_BIT];

endmodule : hsa_aggregator

// >>> tb/hsa_aggregator_sva.sv
// Concurrent checks on the health status aggregator ports.
// Assumes one clock domain and the synchronous active-low reset of the design.
`timescale 1ns/10ps
module hsa_aggregator_sva #(
  parameter int DECAY_PERIOD = hsa_pkg::DECAY_CYCLES,
  parameter int SOFT_CNT_W = hsa_pkg::SOFT_CNT_W
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire hsa_pkg::hsa_hard_in_t hard_in,
  input wire hsa_pkg::hsa_alert_in_t alert_in,
  input wire logic hw_soft_event,
  input wire logic sw_soft_event,
  input wire logic link_alert_in,
  input wire logic sw_alert_in,
  input wire logic link_alert_en,
  input wire logic sw_alert_en,
  input wire hsa_pkg::hsa_words_t words,
  input wire logic [15:0] hw_alert_mask,
  input wire logic [15:0] sensor_alert_mask,
  input wire logic fatal_fault_pin
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  logic [15:0] hs;
  assign hs = words.health_summary_word;
  // Four back-to-back soft events reach the trip level with no decay in between
  sequence s_hw_burst;
    hw_soft_event [*4];
  endsequence
  a_pin_mirror: assert property (fatal_fault_pin == hs[0])
    else $error("fault pin differs from fatal summary bit");
  a_hard_fatal: assert property (|hard_in |=> hs[0] && fatal_fault_pin)
    else $error("hard fault did not raise fatal");
  a_persist_fatal: assert property (s_hw_burst |-> ##[2:3] fatal_fault_pin)
    else $error("persistent soft fault did not raise fatal");
  a_hw_word_map: assert property (1 |=> words.hw_fault_word == {8'h00, $past(hard_in.selfcheck_fault_b),
    $past(hard_in.selfcheck_fault_a), $past(hard_in.rate_sensor_fault), $past(hard_in.accel_fault), 4'h0})
    else $error("hardware fault word layout wrong");
  a_hw_summary: assert property (1 |=> hs[1] == ((|words.hw_fault_word) || $past(hw_soft_event)))
    else $error("hardware error summary wrong");
  a_sw_summary: assert property (1 |=> words.sw_data_fault_word == {15'h0000, $past(hard_in.cal_checksum_fault)}
    && hs[3] == (words.sw_data_fault_word[0] || $past(sw_soft_event)))
    else $error("software error summary wrong");
  a_alert_map: assert property (1 |=> words.hw_alert_word == {10'h000, $past(alert_in.rate_anomaly_seen),
    $past(alert_in.accel_anomaly_seen), $past(alert_in.nvm_write_open), 3'h0})
    else $error("hardware alert word layout wrong");
  a_hw_alert_mask: assert property (1 |=> hs[9] == |(words.hw_alert_word & $past(hw_alert_mask)))
    else $error("hardware alert summary ignores mask");
  a_sensor_alert: assert property (1 |=> words.sensor_alert_word == {15'h0000, $past(alert_in.range_exceeded)}
    && hs[12] == (words.sensor_alert_word[0] && $past(sensor_alert_mask[0])))
    else $error("sensor alert summary wrong");
  a_alert_or: assert property (1 |=> hs[11] == ($past(sw_alert_in) && $past(sw_alert_en))
    && hs[8] == (hs[9] || hs[11] || hs[12] || ($past(link_alert_in) && $past(link_alert_en))))
    else $error("alert summary is not the OR of categories");
  a_mask_default: assert property ($rose(rst_n) |-> sensor_alert_mask == 16'h0001 && hw_alert_mask == 16'h0000)
    else $error("enable masks wrong after reset");
  a_reserved_zero: assert property ((hs & ~hsa_pkg::HS_VALID_MASK) == 16'h0000
    && (hw_alert_mask & ~hsa_pkg::HA_VALID_MASK) == 16'h0000)
    else $error("reserved bit set");
endmodule : hsa_aggregator_sva

bind hsa_aggregator hsa_aggregator_sva #(.DECAY_PERIOD(DECAY_PERIOD), .SOFT_CNT_W(SOFT_CNT_W)) u_sva (
  .core_clk, .rst_n, .hard_in, .alert_in, .hw_soft_event, .sw_soft_event, .link_alert_in, .sw_alert_in,
  .link_alert_en, .sw_alert_en, .words, .hw_alert_mask, .sensor_alert_mask, .fatal_fault_pin);

// >>> tb/hsa_host_mon.sv
// Host-side monitor that polls the fault pin and the health word together.
// Assumes it shares the block's clock; its count survives resets so nothing is lost.
`timescale 1ns/10ps
module hsa_host_mon (
  input wire logic core_clk,
  input wire hsa_pkg::hsa_words_t words,
  input wire logic fatal_fault_pin,
  output logic [15:0] pin_err_q = 16'h0000
);
  always_ff @(posedge core_clk) begin
    if (fatal_fault_pin !== words.health_summary_word[0]) begin
      pin_err_q <= pin_err_q + 16'h0001;
    end
  end
endmodule : hsa_host_mon

// >>> tb/tb_top.sv
// Self-checking bench for the health status aggregator with a cycle model of every output.
// Assumes the design package is compiled first; the decay period is shortened to keep runs brief.
`timescale 1ns/10ps
module tb_top;
  localparam int DP = 4;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  hsa_pkg::hsa_hard_in_t hard_in;
  hsa_pkg::hsa_alert_in_t alert_in;
  logic hw_soft_event, sw_soft_event, link_soft_event, link_alert_in, sw_alert_in;
  logic hw_alert_mask_we, sensor_alert_mask_we, link_alert_en, sw_alert_en;
  logic [15:0] hw_alert_mask_in, sensor_alert_mask_in, hw_alert_mask, sensor_alert_mask, pin_err_q;
  hsa_pkg::hsa_words_t words, exp_w;
  logic hw_fault_summary_soft, sw_fault_summary_soft, link_fault_summary_soft, fatal_fault_pin;
  logic [15:0] m_hw_mask, m_sen_mask, hs;
  logic [2:0] exp_soft, ev;
  int lvl[3];
  bit pers[3];
  bit tk;
  int tick_cnt;
  int bad_count = 0;
  int num_checks = 0;
  logic [31:0] seed = 32'h00004c12;

  always #2.5 core_clk = ~core_clk;

  hsa_aggregator #(.DECAY_PERIOD(DP)) u_hsa_aggregator (.core_clk, .rst_n, .hard_in, .alert_in,
    .hw_soft_event, .sw_soft_event, .link_soft_event, .link_alert_in, .sw_alert_in, .hw_alert_mask_in,
    .hw_alert_mask_we, .sensor_alert_mask_in, .sensor_alert_mask_we, .link_alert_en, .sw_alert_en, .words,
    .hw_alert_mask, .sensor_alert_mask, .hw_fault_summary_soft, .sw_fault_summary_soft,
    .link_fault_summary_soft, .fatal_fault_pin);
  hsa_host_mon u_hsa_host_mon (.core_clk, .words, .fatal_fault_pin, .pin_err_q);

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk16

  // Model runs at the edge on the inputs held there; soft levels decay one step per tick
  task automatic model_step();
    ev = {hw_soft_event, sw_soft_event, link_soft_event};
    if (!rst_n) begin
      exp_w = '0;
      exp_soft = 3'h0;
      m_hw_mask = 16'h0000;
      m_sen_mask = 16'h0001;
      tick_cnt = 0;
      tk = 1'b0;
      foreach (lvl[i]) begin
        lvl[i] = 0;
        pers[i] = 1'b0;
      end
    end else begin
      exp_w.hw_fault_word = {8'h00, hard_in.selfcheck_fault_b, hard_in.selfcheck_fault_a,
        hard_in.rate_sensor_fault, hard_in.accel_fault, 4'h0};
      exp_w.sw_data_fault_word = {15'h0000, hard_in.cal_checksum_fault};
      exp_w.hw_alert_word = {10'h000, alert_in.rate_anomaly_seen, alert_in.accel_anomaly_seen,
        alert_in.nvm_write_open, 3'h0};
      exp_w.sensor_alert_word = {15'h0000, alert_in.range_exceeded};
      hs = 16'h0000;
      hs[0] = (|hard_in) | pers[0] | pers[1] | pers[2];
      hs[1] = (|exp_w.hw_fault_word) | ev[2];
      hs[3] = hard_in.cal_checksum_fault | ev[1];
      hs[9] = |(exp_w.hw_alert_word & m_hw_mask);
      hs[11] = sw_alert_in & sw_alert_en;
      hs[12] = alert_in.range_exceeded & m_sen_mask[0];
      hs[8] = hs[9] | hs[11] | hs[12] | (link_alert_in & link_alert_en);
      exp_w.health_summary_word = hs;
      exp_soft = ev;
      if (hw_alert_mask_we) m_hw_mask = hw_alert_mask_in & 16'h0038;
      if (sensor_alert_mask_we) m_sen_mask = sensor_alert_mask_in & 16'h0001;
      // The divider's tick is registered, so a decay lands one edge after its count wraps
      for (int i = 0; i < 3; i++) begin
        pers[i] = pers[i] | (lvl[i] >= 64);
        if (ev[i]) lvl[i] = (lvl[i] + 16 > 255) ? 255 : lvl[i] + 16;
        else if (tk && lvl[i] > 0) lvl[i]--;
      end
      tk = (tick_cnt == DP - 1);
      tick_cnt = tk ? 0 : tick_cnt + 1;
    end
  endtask : model_step

  task automatic cyc();
    @(posedge core_clk);
    model_step();
    #1;
    chk16("health", exp_w.health_summary_word, words.health_summary_word);
    chk16("hw_fault", exp_w.hw_fault_word, words.hw_fault_word);
    chk16("sw_data", exp_w.sw_data_fault_word, words.sw_data_fault_word);
    chk16("hw_alert", exp_w.hw_alert_word, words.hw_alert_word);
    chk16("sensor_alert", exp_w.sensor_alert_word, words.sensor_alert_word);
    chk16("hw_mask", m_hw_mask, hw_alert_mask);
    chk16("sensor_mask", m_sen_mask, sensor_alert_mask);
    chk16("pin", {15'h0000, exp_w.health_summary_word[0]}, {15'h0000, fatal_fault_pin});
    chk16("soft", {13'h0000, exp_soft}, {13'h0000, hw_fault_summary_soft, sw_fault_summary_soft,
      link_fault_summary_soft});
  endtask : cyc

  task automatic clear_in();
    hard_in = '0;
    alert_in = '0;
    {hw_soft_event, sw_soft_event, link_soft_event, link_alert_in, sw_alert_in} = 5'h00;
    {hw_alert_mask_we, sensor_alert_mask_we, link_alert_en, sw_alert_en} = 4'h0;
    hw_alert_mask_in = 16'h0000;
    sensor_alert_mask_in = 16'h0000;
  endtask : clear_in

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  initial begin
    #100000;
    bad_count++;
    close_out();
  end

  initial begin
    logic [31:0] r;
    clear_in();
    repeat (6) cyc();
    rst_n = 1'b1;
    alert_in.range_exceeded = 1'b1;
    repeat (2) cyc();
    for (int b = 0; b < 5; b++) begin
      alert_in = '0;
      hard_in = 5'(1 << b);
      cyc();
      hard_in = '0;
      cyc();
    end
    repeat (400) begin
      r = xs();
      hard_in = (r[7:5] == 3'h0) ? r[4:0] : 5'h00;
      alert_in = r[11:8];
      {link_alert_in, sw_alert_in, link_alert_en, sw_alert_en} = r[15:12];
      hw_alert_mask_in = r[31:16];
      sensor_alert_mask_in = {r[3:0], r[31:20]};
      hw_alert_mask_we = r[21] & r[22];
      sensor_alert_mask_we = r[23] & r[24];
      link_soft_event = r[25] & r[26] & r[27];
      cyc();
    end
    clear_in();
    // Random link bursts may have latched fatal; clear it so the soft checks mean something
    rst_n = 1'b0;
    repeat (2) cyc();
    rst_n = 1'b1;
    for (int k = 0; k < 2; k++) begin
      repeat (3) begin
        sw_soft_event = 1'b1;
        cyc();
      end
      sw_soft_event = 1'b0;
      repeat (200) cyc();
    end
    chk16("no_fatal", 16'h0000, {15'h0000, fatal_fault_pin});
    repeat (4) begin
      hw_soft_event = 1'b1;
      cyc();
    end
    hw_soft_event = 1'b0;
    repeat (12) cyc();
    chk16("fatal_latched", 16'h0001, {15'h0000, fatal_fault_pin});
    rst_n = 1'b0;
    repeat (2) cyc();
    rst_n = 1'b1;
    alert_in.range_exceeded = 1'b1;
    repeat (3) cyc();
    chk16("host_pin_err", 16'h0000, pin_err_q);
    close_out();
  end
endmodule : tb_top
